// *** dtc_consts.svh ***
// Purpose: constants of the dram termination control block
// Assumes: one aligned 32-bit word per register on the bus
// Notes:   offsets, field positions, reset values and timing counts
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register byte offsets
`define DTC_ADDR_MODE_ONE 8'h00
`define DTC_ADDR_MODE_TWO 8'h04
`define DTC_ADDR_CTRL     8'h08
`define DTC_ADDR_STATUS   8'h0C

// mode register field positions
`define DTC_M1_NOM_HI 9
`define DTC_M1_NOM_MI 6
`define DTC_M1_NOM_LO 2
`define DTC_M2_WR_HI  10
`define DTC_M2_WR_LO  9

// control register fields
`define DTC_CT_DLL_OFF 0
`define DTC_CT_SELF    1
`define DTC_CT_ASYNC   2
`define DTC_CT_CWL_LSB 4
`define DTC_CT_AL_LSB  8

// reset values
`define DTC_RST_MODE_ONE 32'h0000_0000
`define DTC_RST_MODE_TWO 32'h0000_0000
`define DTC_RST_CWL      4'h5
`define DTC_RST_AL       4'h0

// timing
`define DTC_CLK_MHZ       250
`define DTC_ASYNC_MIN_NS  1
`define DTC_ASYNC_MAX_NS  9
`define DTC_ASYNC_CYC     ((`DTC_ASYNC_MAX_NS * `DTC_CLK_MHZ) / 1000)
`define DTC_LAT_OFFSET    2
`define DTC_HOLD_SHORT    3'h4
`define DTC_HOLD_LONG     3'h6
`define DTC_NOM_ILL_A     3'h6
`define DTC_NOM_ILL_B     3'h7
`define DTC_WR_ILL        2'h3

`endif

// *** dtc_pkg.sv ***
// Purpose: shared types of the dram termination control block
// Assumes: constants live in dtc_consts.svh
// Notes:   pins and termination state travel as packed structs
package dtc_pkg;

   // pins sampled from the controller side
   typedef struct packed {
      logic term_ctl_pin;
      logic cke;
      logic write_cmd;
      logic burst_length_eight;
      logic refresh_cmd;
   } dtc_pins_type;

   // termination switch state
   typedef struct packed {
      logic       on;
      logic       write_sel;
      logic [2:0] code;
   } dtc_term_type;

   // termination timing mode
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_SYNC,
      MODE_ASYNC
   } dtc_mode_type;

endpackage

// *** dtc_sync.sv ***
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: reset is already synchronous in release
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module dtc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   // two stages per bit
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// *** dtc_delay_line.sv ***
// Purpose: latency pipeline advanced on command-clock rising edges
// Assumes: shift is a one-cycle pulse per command-clock edge
// Notes:   tap 0 passes the input straight through
`timescale 1ns/10ps
module dtc_delay_line #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // control
   input  wire logic                     shift,
   input  wire logic [$clog2(DEPTH)-1:0] tap,
   // data
   input  wire logic [WIDTH-1:0]         din,
   output logic      [WIDTH-1:0]         dout
);

   logic [WIDTH-1:0] line_reg [DEPTH];

   // stage storage, cleared by reset
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_stage
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               line_reg[i] <= '0;
            end else if (shift) begin
               line_reg[i] <= (i == 0) ? din : line_reg[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   // selected tap
   always_comb begin
      if (tap == '0) begin
         dout = din;
      end else begin
         dout = line_reg[tap - 1'b1];
      end
   end

endmodule

// *** dtc_top.sv ***
// Purpose: on-die termination control with AHB-Lite register access
// Assumes: command clock slower than a quarter of the core clock
// Notes:   controller pins are sampled on command-clock rising edges, except the device reset and the cke bit of the status register
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "dtc_consts.svh"
module dtc_top #(
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                arst_n,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic      [31:0]         hrdata,
   output logic                     hresp,
   // controller pins
   input  wire logic                link_clk,
   input  wire logic                dev_reset_n,
   input  wire dtc_pkg::dtc_pins_type pins,
   // termination and output control
   output dtc_pkg::dtc_term_type    term_out,
   output logic                     out_enable
);

   localparam int TW = $clog2(DEPTH);

   logic [1:0]            sys_rst_reg;
   logic [1:0]            dev_rst_reg;
   logic                  sys_rst_n;
   logic                  core_rst_n;
   logic                  link_s;
   logic                  link_d_reg;
   logic                  tick;
   dtc_pkg::dtc_pins_type pins_s;
   dtc_pkg::dtc_pins_type smp_reg;
   logic [31:0]           mode_one_reg;
   logic [31:0]           mode_two_reg;
   logic                  dll_off_reg;
   logic                  self_ref_reg;
   logic                  async_reg;
   logic [3:0]            cwl_reg;
   logic [3:0]            al_reg;
   logic                  wr_pend_reg;
   logic [7:0]            wr_addr_reg;
   logic [2:0]            nom_code;
   logic [1:0]            wr_code;
   logic                  nom_ok;
   logic                  wr_ok;
   logic                  dyn_en;
   logic [4:0]            lat_sum;
   logic [TW-1:0]         lat;
   logic [2:0]            line_in;
   logic [2:0]            line_out;
   dtc_pkg::dtc_mode_type mode_next;
   dtc_pkg::dtc_mode_type mode_reg;
   logic [`DTC_ASYNC_CYC-1:0] async_pipe_reg;
   logic [2:0]            wr_cnt_reg;
   logic                  pin_eff;
   logic                  dyn_act;
   dtc_pkg::dtc_term_type term_next;
   logic [15:0]           ref_cnt_reg;
   logic                  addr_ok;

   // bus reset: only the system reset, released through two flops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sys_rst_reg <= 2'h0;
      end else begin
         sys_rst_reg <= {sys_rst_reg[0], 1'b1};
      end
   end
   assign sys_rst_n = sys_rst_reg[1];

   // core reset: device reset pin acts at once, release is synchronous
   always_ff @(posedge clock or negedge arst_n or negedge dev_reset_n) begin
      if (!arst_n || !dev_reset_n) begin
         dev_rst_reg <= 2'h0;
      end else begin
         dev_rst_reg <= {dev_rst_reg[0], 1'b1};
      end
   end
   assign core_rst_n = dev_rst_reg[1];

   // pin synchronisers
   dtc_sync #(.WIDTH(1)) u_link_sync (
      .clock (clock),
      .rst_n (sys_rst_n),
      .d     (link_clk),
      .q     (link_s)
   );

   dtc_sync #(.WIDTH($bits(dtc_pkg::dtc_pins_type))) u_pin_sync (
      .clock (clock),
      .rst_n (sys_rst_n),
      .d     (pins),
      .q     (pins_s)
   );

   // command-clock rising edge finder
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         link_d_reg <= 1'b0;
      end else begin
         link_d_reg <= link_s;
      end
   end
   assign tick = link_s & ~link_d_reg;

   // pins registered on each command-clock rising edge
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         smp_reg <= '0;
      end else if (tick) begin
         smp_reg <= pins_s;
      end
   end

   // field decode
   assign nom_code = {mode_one_reg[`DTC_M1_NOM_HI],
                      mode_one_reg[`DTC_M1_NOM_MI],
                      mode_one_reg[`DTC_M1_NOM_LO]};
   assign wr_code  = {mode_two_reg[`DTC_M2_WR_HI],
                      mode_two_reg[`DTC_M2_WR_LO]};
   assign nom_ok   = (nom_code != 3'h0) &&
                     (nom_code != `DTC_NOM_ILL_A) &&
                     (nom_code != `DTC_NOM_ILL_B);
   assign dyn_en   = (wr_code != 2'h0);
   assign wr_ok    = dyn_en && (wr_code != `DTC_WR_ILL);

   // latency in command-clock cycles, clamped at zero
   assign lat_sum = {1'b0, cwl_reg} + {1'b0, al_reg};
   always_comb begin
      if (lat_sum > 5'(`DTC_LAT_OFFSET)) begin
         lat = TW'(lat_sum - 5'(`DTC_LAT_OFFSET));
      end else begin
         lat = '0;
      end
   end

   // pin level, write with dynamic mode, burst length into the pipeline
   assign line_in = {smp_reg.term_ctl_pin,
                     smp_reg.write_cmd & dyn_en,
                     smp_reg.burst_length_eight};

   dtc_delay_line #(.WIDTH(3), .DEPTH(DEPTH)) u_line (
      .clock (clock),
      .rst_n (core_rst_n),
      .shift (tick),
      .tap   (lat),
      .din   (line_in),
      .dout  (line_out)
   );

   // timing mode selection
   always_comb begin
      if (dll_off_reg) begin
         mode_next = dtc_pkg::MODE_OFF;
      end else if (self_ref_reg || (nom_code == 3'h0 && !dyn_en)) begin
         mode_next = dtc_pkg::MODE_OFF;
      end else if (async_reg) begin
         mode_next = dtc_pkg::MODE_ASYNC;
      end else begin
         mode_next = dtc_pkg::MODE_SYNC;
      end
   end

   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode_reg <= dtc_pkg::MODE_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // asynchronous path: fixed core-clock delay inside the 1 to 9 ns band
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         async_pipe_reg <= '0;
      end else begin
         async_pipe_reg <= {async_pipe_reg[`DTC_ASYNC_CYC-2:0],
                            smp_reg.term_ctl_pin};
      end
   end

   // write termination window, counted in command-clock cycles
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         wr_cnt_reg <= 3'h0;
      end else if (mode_reg != dtc_pkg::MODE_SYNC) begin
         wr_cnt_reg <= 3'h0;
      end else if (tick) begin
         if (line_out[1]) begin
            wr_cnt_reg <= line_out[0] ? `DTC_HOLD_LONG - 3'h1
                                      : `DTC_HOLD_SHORT - 3'h1;
         end else if (wr_cnt_reg != 3'h0) begin
            wr_cnt_reg <= wr_cnt_reg - 3'h1;
         end
      end
   end
   // window opens as the write reaches the tap; the counter holds the rest
   assign dyn_act = (mode_reg == dtc_pkg::MODE_SYNC) &&
                    (line_out[1] || (wr_cnt_reg != 3'h0));

   // effective termination
   always_comb begin
      term_next = '0;
      pin_eff   = 1'b0;
      case (mode_reg)
         dtc_pkg::MODE_SYNC: begin
            pin_eff = line_out[2];
         end
         dtc_pkg::MODE_ASYNC: begin
            pin_eff = async_pipe_reg[`DTC_ASYNC_CYC-1];
         end
         default: begin
            pin_eff = 1'b0;
         end
      endcase
      if (pin_eff && dyn_act && wr_ok) begin
         term_next.on        = 1'b1;
         term_next.write_sel = 1'b1;
         term_next.code      = {1'b0, wr_code};
      end else if (pin_eff && nom_ok) begin
         term_next.on   = 1'b1;
         term_next.code = nom_code;
      end
   end

   // termination switch and output enable
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         term_out   <= '0;
         out_enable <= 1'b0;
      end else begin
         term_out   <= term_next;
         out_enable <= 1'b1;
      end
   end

   // refresh counter, cleared by any reset
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         ref_cnt_reg <= 16'h0000;
      end else if (tick && pins_s.refresh_cmd && pins_s.cke) begin
         ref_cnt_reg <= ref_cnt_reg + 16'h0001;
      end
   end

   // bus address phase capture
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= hsel && htrans[1] && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // mode and control registers; device reset loads their reset values too
   always_ff @(posedge clock or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode_one_reg <= `DTC_RST_MODE_ONE;
         mode_two_reg <= `DTC_RST_MODE_TWO;
         dll_off_reg  <= 1'b0;
         self_ref_reg <= 1'b0;
         async_reg    <= 1'b0;
         cwl_reg      <= `DTC_RST_CWL;
         al_reg       <= `DTC_RST_AL;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == `DTC_ADDR_MODE_ONE) begin
            mode_one_reg <= hwdata;
         end else if (wr_addr_reg == `DTC_ADDR_MODE_TWO) begin
            mode_two_reg <= hwdata;
         end else if (wr_addr_reg == `DTC_ADDR_CTRL) begin
            dll_off_reg  <= hwdata[`DTC_CT_DLL_OFF];
            self_ref_reg <= hwdata[`DTC_CT_SELF];
            async_reg    <= hwdata[`DTC_CT_ASYNC];
            cwl_reg      <= hwdata[`DTC_CT_CWL_LSB +: 4];
            al_reg       <= hwdata[`DTC_CT_AL_LSB +: 4];
         end
      end
   end

   // read data, registered in the address phase
   assign addr_ok = hsel && htrans[1] && !hwrite && hready;
   always_ff @(posedge clock or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok) begin
         if (haddr[7:0] == `DTC_ADDR_MODE_ONE) begin
            hrdata <= mode_one_reg;
         end else if (haddr[7:0] == `DTC_ADDR_MODE_TWO) begin
            hrdata <= mode_two_reg;
         end else if (haddr[7:0] == `DTC_ADDR_CTRL) begin
            hrdata <= {20'h00000, al_reg, cwl_reg, 1'b0,
                       async_reg, self_ref_reg, dll_off_reg};
         end else if (haddr[7:0] == `DTC_ADDR_STATUS) begin
            hrdata <= {ref_cnt_reg, 3'h0, pins_s.cke, dyn_act,
                       !wr_ok && dyn_en, !nom_ok && nom_code != 3'h0,
                       mode_reg == dtc_pkg::MODE_ASYNC, 3'h0,
                       term_out};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // always ready, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule

// *** dtc_assertions.sv ***
// Purpose: port checks of the termination block
// Assumes: bench latencies stay at or below five command cycles
// Notes:   helper counters measure distance to the causing pin
`timescale 1ns/10ps
module dtc_assertions #(
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic                  clock,
   input wire logic                  arst_n,
   // controller pins
   input wire logic                  link_clk,
   input wire logic                  dev_reset_n,
   input wire dtc_pkg::dtc_pins_type pins,
   // termination
   input wire dtc_pkg::dtc_term_type term_out,
   input wire logic                  out_enable
);
   localparam int PIN_WAIT = 200;
   localparam int WR_WAIT  = 400;
   logic [7:0] low_cnt;
   logic [8:0] wr_cnt;
   logic [4:0] rise_cnt;
   logic       link_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // cycles since pin high, since write, since command-clock rise
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt  <= 8'hFF;
         wr_cnt   <= 9'h1FF;
         rise_cnt <= 5'h1F;
         link_q   <= 1'b0;
      end else begin
         link_q   <= link_clk;
         low_cnt  <= pins.term_ctl_pin ? 8'h00 :
                     low_cnt + 8'(low_cnt != 8'hFF);
         wr_cnt   <= pins.write_cmd ? 9'h000 : wr_cnt + 9'(wr_cnt != 9'h1FF);
         rise_cnt <= (link_clk && !link_q) ? 5'h00 :
                     rise_cnt + 5'(rise_cnt != 5'h1F);
      end
   end
   reset_term_off_a: assert property (
      !dev_reset_n |-> term_out == '0 && !out_enable)
      else $error("termination or outputs active in reset");
   reset_release_a: assert property (
      $rose(dev_reset_n) |-> ##[1:4] out_enable)
      else $error("outputs not enabled after reset");
   reset_quiet_a: assert property (
      $rose(dev_reset_n) |-> (!term_out.on) [*4])
      else $error("termination on straight after reset");
   nom_code_legal_a: assert property (
      term_out.on |-> term_out.code < 3'h6)
      else $error("reserved nominal code applied");
   wr_code_legal_a: assert property (term_out.write_sel |->
      term_out.on && term_out.code inside {3'h1, 3'h2})
      else $error("bad write termination code");
   pin_cause_a: assert property (
      term_out.on |-> low_cnt < PIN_WAIT)
      else $error("termination on without the pin");
   wr_cause_a: assert property (
      term_out.write_sel |-> wr_cnt < WR_WAIT)
      else $error("write termination without a write");
   on_edge_a: assert property (
      $rose(term_out.on) |-> rise_cnt inside {[1:12]})
      else $error("termination turned on off the command clock");
   cover property ($rose(term_out.on));
   cover property ($rose(term_out.write_sel));
   cover property ($fell(dev_reset_n));
endmodule

// *** dtc_ctl_model.sv ***
// Purpose: memory controller model making command clock and pins
// Assumes: core clock 4 ns, command clock 80 ns, free running
// Notes:   pins change only at command-clock falling edges
`timescale 1ns/10ps
module dtc_ctl_model (
   // clock
   input  wire logic             clock,
   // controller pins
   output logic                  link_clk,
   output dtc_pkg::dtc_pins_type pins
);
   logic [3:0] half_cnt = 4'h0;
   int         hold     = 0;
   initial link_clk = 1'b0;
   initial pins = '0;
   // ten core cycles per half period
   always @(posedge clock) begin
      half_cnt <= (half_cnt == 4'h9) ? 4'h0 : half_cnt + 4'h1;
      if (half_cnt == 4'h9) link_clk <= ~link_clk;
   end
   // one command cycle of pins; hold times are kept here
   task automatic step(input logic t, input logic w, input logic b,
                       input logic r, input logic c);
      do @(posedge clock); while (!(link_clk && half_cnt == 4'h9));
      if (hold > 0) t = 1'b1;
      if (t && w) hold = b ? 5 : 3;
      else if (t && !pins.term_ctl_pin) hold = 3;
      else if (hold > 0) hold--;
      pins <= '{t, c, w, b, r};
   endtask
endmodule

// *** dtc_tb_top.sv ***
// Purpose: self-checking bench of the termination block
// Assumes: controller model steps one command cycle per call
// Notes:   bus tasks follow the zero-wait slave handshake
`timescale 1ns/10ps
module dtc_tb_top;
   localparam int DEPTH = 32;
   logic                  clock = 1'b0;
   logic                  arst_n = 1'b0;
   logic                  hsel = 1'b1;
   logic [31:0]           haddr = 32'h0;
   logic [1:0]            htrans = 2'h0;
   logic                  hwrite = 1'b0;
   logic [2:0]            hsize = 3'h2;
   logic [31:0]           hwdata = 32'h0;
   logic                  hready;
   logic                  hreadyout;
   logic [31:0]           hrdata;
   logic                  hresp;
   logic                  link_clk;
   logic                  dev_reset_n = 1'b0;
   dtc_pkg::dtc_pins_type pins;
   dtc_pkg::dtc_term_type term_out;
   logic                  out_enable;
   logic [31:0]           rd;
   int                    miscompares = 0;
   int                    checked = 0;
   int                    cyc = 0;
   logic [31:0]           ctl_val [5] = '{32'h50, 32'h160, 32'h54,
                                          32'h52, 32'h51};
   int                    ctl_lat [5] = '{5, 7, 2, 0, 0};
   logic [31:0]           dyn_mr [4] = '{32'h200, 32'h400, 32'h0, 32'h600};
   logic [31:0]           dyn_6 [4] = '{32'h19, 32'h1A, 32'h11, 32'h11};
   logic [31:0]           dyn_9 [4] = '{32'h19, 32'h11, 32'h11, 32'h11};
   assign hready = hreadyout;
   always #2 clock = ~clock;
   // design, controller model
   dtc_top #(.DEPTH(DEPTH)) dtc_top_inst (
      .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .link_clk(link_clk), .dev_reset_n(dev_reset_n),
      .pins(pins), .term_out(term_out), .out_enable(out_enable));
   dtc_ctl_model dtc_ctl_model_inst (
      .clock(clock), .link_clk(link_clk), .pins(pins));
   task automatic finish_test;
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // single ahb-lite transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic rchk(input string nm, input logic [31:0] a,
                       input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
      chk("bus response", 32'(hresp), 32'h0);
   endtask
   task automatic st(input logic t, input logic w, input logic b,
                     input logic r, input logic c);
      dtc_ctl_model_inst.step(t, w, b, r, c);
   endtask
   // pin high for at least four steps and until on (or refused), then low until off; a latency of n
   // shows after n + 2 steps: one to register, one to reach the next fall
   task automatic pulse(input int exp_n, input logic [4:0] exp_t);
      int i;
      int hit;
      i = 0;
      hit = 0;
      while (i < 4 || (hit == 0 && i < 12)) begin
         st(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
         i++;
         if (hit == 0 && term_out.on === 1'b1) begin
            hit = i;
            chk("term state", 32'(term_out), 32'(exp_t));
         end
      end
      chk("on steps", 32'(hit), 32'(exp_n));
      if (hit != 0) begin
         i = 0;
         do begin
            st(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            i++;
         end while (term_out.on !== 1'b0 && i < 12);
         chk("off steps", 32'(i), 32'(exp_n));
      end
      repeat (8) st(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
   endtask
   // cycle ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      repeat (20) @(posedge clock);
      dev_reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk("out enable", 32'(out_enable), 32'h1);
      rchk("mode one", 32'h00, 32'h0);
      rchk("mode two", 32'h04, 32'h0);
      rchk("ctrl", 32'h08, 32'h50);
      rchk("status", 32'h0C, 32'h0);
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF, rd);
      rchk("unmapped", 32'h10, 32'h0);
      for (int c = 0; c < 8; c++) begin
         ahb(1'b1, 32'h00, {22'h0, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0}, rd);
         pulse((c > 0 && c < 6) ? 5 : 0, 5'h10 | 5'(c));
      end
      ahb(1'b1, 32'h00, 32'h4, rd);
      for (int k = 0; k < 5; k++) begin
         ahb(1'b1, 32'h08, ctl_val[k], rd);
         pulse(ctl_lat[k], 5'h11);
      end
      ahb(1'b1, 32'h08, 32'h50, rd);
      for (int k = 0; k < 4; k++) begin
         ahb(1'b1, 32'h04, dyn_mr[k], rd);
         st(1'b1, 1'b1, k == 0, 1'b0, 1'b1);
         for (int i = 2; i <= 12; i++) begin
            st(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
            if (i == 6)
               chk("write term", 32'(term_out), dyn_6[k]);
            if (i == 9)
               chk("write end", 32'(term_out), dyn_9[k]);
         end
         chk("after write", 32'(term_out), 32'h11);
         repeat (8) st(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      end
      repeat (3) st(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      st(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      rchk("refresh count", 32'h0C, 32'h0003_1400);
      repeat (4) st(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk("on before reset", 32'(term_out.on), 32'h1);
      dev_reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("reset term", 32'(term_out), 32'h0);
      chk("reset outputs", 32'(out_enable), 32'h0);
      repeat (26) @(posedge clock);
      dev_reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      rchk("status reset", 32'h0C, 32'h0);
      rchk("mode reset", 32'h00, 32'h0);
      finish_test;
   end
endmodule
bind dtc_top dtc_assertions #(.DEPTH(DEPTH)) dtc_assertions_inst (
   .clock(clock), .arst_n(arst_n), .link_clk(link_clk),
   .dev_reset_n(dev_reset_n), .pins(pins), .term_out(term_out),
   .out_enable(out_enable));
